/* gdp_gpio.sv */
// Purpose: two 8-bit ports with latches, directions and pin sharing
// Assumes: pins and peripheral returns arrive on clk or from outside
// Notes: data latches have no reset; second-port pin drive is one clock behind

`timescale 1ns/1ps
`default_nettype none

module gdp_gpio
  import gdp_pkg::*;
#(
  parameter int unsigned PORT_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [PORT_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [PORT_W-1:0] reg_rdata,
  input wire logic [PORT_W-1:0] pb_in,
  output logic [PORT_W-1:0] pb_out,
  output logic [PORT_W-1:0] pb_oe,
  input wire logic [PORT_W-1:0] pd_in,
  output logic [PORT_W-1:0] pd_out,
  output logic [PORT_W-1:0] pd_oe,
  output logic [1:0] pd_pullup_en,
  output logic [1:0] pd_slow_edge,
  input wire logic ser_tx,
  output logic ser_rx,
  input wire logic [1:0] tmr_out,
  input wire logic [1:0] tmr_oe,
  output logic [1:0] tmr_in,
  input wire logic [1:0] tw_low,
  output logic [1:0] tw_in
);

  ////////////////////////////////////////////////////////////////////////
  // elaboration check

  // pin positions 4..7 and the 8-bit register port are fixed
  if (PORT_W != 8) begin : g_bad_width
    $error("gdp_gpio supports PORT_W of 8 only");
  end

  ////////////////////////////////////////////////////////////////////////
  // state

  logic [PORT_W-1:0] first_port_latch_reg;
  logic [PORT_W-1:0] second_port_latch_reg;
  logic [PORT_W-1:0] first_port_direction_reg;
  logic [PORT_W-1:0] first_port_direction_next;
  logic [PORT_W-1:0] second_port_direction_reg;
  logic [PORT_W-1:0] second_port_direction_next;
  logic [7:0] second_port_drive_control_reg;
  logic [7:0] second_port_drive_control_next;
  logic [7:0] share_ctl_reg;
  logic [7:0] share_ctl_next;
  logic [PORT_W-1:0] rdata_reg;
  logic [PORT_W-1:0] rdata_next;
  logic [PORT_W-1:0] pd_out_reg;
  logic [PORT_W-1:0] pd_oe_reg;
  logic [PORT_W-1:0] pb_meta;
  logic [PORT_W-1:0] pb_sync;
  logic [PORT_W-1:0] pd_meta;
  logic [PORT_W-1:0] pd_sync;

  ////////////////////////////////////////////////////////////////////////
  // register decode

  wire logic wr_first_latch;
  wire logic wr_second_latch;
  wire logic wr_first_dir;
  wire logic wr_second_dir;
  wire logic wr_drive;
  wire logic wr_share;

  // one-hot write strobes per register
  assign wr_first_latch = reg_wr && (reg_addr == A_FIRST_LATCH);
  assign wr_second_latch = reg_wr && (reg_addr == A_SECOND_LATCH);
  assign wr_first_dir = reg_wr && (reg_addr == A_FIRST_DIR);
  assign wr_second_dir = reg_wr && (reg_addr == A_SECOND_DIR);
  assign wr_drive = reg_wr && (reg_addr == A_DRIVE_CTL);
  assign wr_share = reg_wr && (reg_addr == A_SHARE_CTL);

  // next values of the reset-bearing control registers
  assign first_port_direction_next = wr_first_dir ? reg_wdata : first_port_direction_reg;
  assign second_port_direction_next = wr_second_dir ? reg_wdata : second_port_direction_reg;
  assign second_port_drive_control_next =
    wr_drive ? (reg_wdata & DRIVE_MASK) : second_port_drive_control_reg;
  assign share_ctl_next = wr_share ? (reg_wdata & SHARE_MASK) : share_ctl_reg;

  ////////////////////////////////////////////////////////////////////////
  // control fields

  wire logic serial_iface_enable;
  wire logic two_wire_enable;
  wire logic tw_route;
  wire logic [1:0] els0;
  wire logic [1:0] els1;
  wire logic [1:0] slow_edge;

  assign serial_iface_enable = share_ctl_reg[F_SER_EN];
  assign two_wire_enable = share_ctl_reg[F_TW_EN];
  assign tw_route = share_ctl_reg[F_TW_ROUTE];
  assign els0 = share_ctl_reg[F_ELS0 +: 2];
  assign els1 = share_ctl_reg[F_ELS1 +: 2];
  assign slow_edge = {second_port_drive_control_reg[F_SLOW7], second_port_drive_control_reg[F_SLOW6]};

  ////////////////////////////////////////////////////////////////////////
  // read path

  wire logic [PORT_W-1:0] rd_first;
  wire logic [PORT_W-1:0] rd_second;
  wire logic [PORT_W-1:0] rd_sel;

  // outputs read the latch, inputs read the synchronised pin
  assign rd_first = (first_port_direction_reg & first_port_latch_reg)
    | (~first_port_direction_reg & pb_sync);
  assign rd_second = (second_port_direction_reg & second_port_latch_reg)
    | (~second_port_direction_reg & pd_sync);

  // unmapped indices read as zero
  assign rd_sel = (reg_addr == A_FIRST_LATCH) ? rd_first :
    (reg_addr == A_SECOND_LATCH) ? rd_second :
    (reg_addr == A_FIRST_DIR) ? first_port_direction_reg :
    (reg_addr == A_SECOND_DIR) ? second_port_direction_reg :
    (reg_addr == A_DRIVE_CTL) ? second_port_drive_control_reg :
    (reg_addr == A_SHARE_CTL) ? share_ctl_reg : RD_IDLE;

  // data stand only in the cycle after the strobe
  assign rdata_next = reg_rd ? rd_sel : RD_IDLE;

  ////////////////////////////////////////////////////////////////////////
  // second-port pin drive, one generate over the bits

  wire logic [PORT_W-1:0] pd_oe_next;
  wire logic [PORT_W-1:0] pd_out_next;

  for (genvar g = 0; g < PORT_W; g++) begin : g_pd
    if (g == PIN_TMR0 || g == PIN_TMR1) begin : g_tmr
      localparam int unsigned T = (g == PIN_TMR0) ? 0 : 1;
      wire logic [1:0] sel;
      assign sel = (T == 0) ? els0 : els1;
      // a nonzero select hands the pin to the timer channel
      assign pd_oe_next[g] = (sel != ELS_GPIO) ? tmr_oe[T] : second_port_direction_reg[g];
      assign pd_out_next[g] = (sel != ELS_GPIO) ? tmr_out[T] : second_port_latch_reg[g];
    end else if (g >= PIN_HC6) begin : g_hc
      localparam int unsigned H = g - PIN_HC6;
      gdp_own_e own;
      logic oe;
      logic out;
      // serial first, then routed two-wire, then the port
      assign own = serial_iface_enable ? OWN_SERIAL :
        (two_wire_enable && tw_route) ? OWN_TWO_WIRE : OWN_GPIO;
      always_comb begin
        unique case (own)
          OWN_SERIAL: begin
            // pin 6 carries transmit, pin 7 stays an input for receive
            oe = (H == 0);
            out = (H == 0) ? ser_tx : 1'b0;
          end
          OWN_TWO_WIRE: begin
            // open-drain: only ever pull low
            oe = tw_low[H];
            out = 1'b0;
          end
          OWN_GPIO: begin
            if (slow_edge[H]) begin
              // open-drain sink; a latched one releases the pin
              oe = second_port_direction_reg[g] & ~second_port_latch_reg[g];
              out = 1'b0;
            end else begin
              oe = second_port_direction_reg[g];
              out = second_port_latch_reg[g];
            end
          end
        endcase
      end
      assign pd_oe_next[g] = oe;
      assign pd_out_next[g] = out;
    end else begin : g_plain
      assign pd_oe_next[g] = second_port_direction_reg[g];
      assign pd_out_next[g] = second_port_latch_reg[g];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flip-flops

  // pin synchronisers; the first stage feeds only the second
  always_ff @(posedge clk) begin
    pb_meta <= pb_in;
    pb_sync <= pb_meta;
    pd_meta <= pd_in;
    pd_sync <= pd_meta;
  end

  // data latches carry no reset, so contents survive a reset
  always_ff @(posedge clk) begin
    if (wr_first_latch) begin
      first_port_latch_reg <= reg_wdata;
    end
    if (wr_second_latch) begin
      second_port_latch_reg <= reg_wdata;
    end
  end

  // control registers and registered outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      first_port_direction_reg <= DIR_RST;
      second_port_direction_reg <= DIR_RST;
      second_port_drive_control_reg <= CTL_RST;
      share_ctl_reg <= CTL_RST;
      rdata_reg <= RD_IDLE;
      pd_oe_reg <= DIR_RST;
      pd_out_reg <= DIR_RST;
    end else begin
      first_port_direction_reg <= first_port_direction_next;
      second_port_direction_reg <= second_port_direction_next;
      second_port_drive_control_reg <= second_port_drive_control_next;
      share_ctl_reg <= share_ctl_next;
      rdata_reg <= rdata_next;
      pd_oe_reg <= pd_oe_next;
      pd_out_reg <= pd_out_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rdata = rdata_reg;
  assign pb_out = first_port_latch_reg;
  assign pb_oe = first_port_direction_reg;
  assign pd_out = pd_out_reg;
  assign pd_oe = pd_oe_reg;
  // pull-ups follow their bits alone, direction plays no part
  assign pd_pullup_en = {second_port_drive_control_reg[F_PU7],
    second_port_drive_control_reg[F_PU6]};
  assign pd_slow_edge = slow_edge;
  // peripherals see the synchronised pins, not the raw ones
  assign ser_rx = pd_sync[PIN_HC6 + 1];
  assign tmr_in = {pd_sync[PIN_TMR1], pd_sync[PIN_TMR0]};
  assign tw_in = {pd_sync[PIN_HC6 + 1], pd_sync[PIN_HC6]};

  ////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_dir_oe;
    wr_first_dir |=> pb_oe == $past(reg_wdata);
  endproperty
  a_dir_oe: assert property (p_dir_oe) else $error("direction write not on output enable");

  property p_first_dir_rst;
    $rose(rst_n) |-> first_port_direction_reg == DIR_RST && pb_oe == DIR_RST;
  endproperty
  a_first_dir_rst: assert property (p_first_dir_rst) else $error("first port not input after reset");

  property p_second_dir_rst;
    $rose(rst_n) |-> second_port_direction_reg == DIR_RST && pd_oe == DIR_RST;
  endproperty
  a_second_dir_rst: assert property (p_second_dir_rst) else $error("second port not input after reset");

  property p_first_keep;
    disable iff (1'b0) !rst_n && !wr_first_latch |=> first_port_latch_reg === $past(first_port_latch_reg);
  endproperty
  a_first_keep: assert property (p_first_keep) else $error("reset changed first port latch");

  property p_second_keep;
    disable iff (1'b0) !rst_n && !wr_second_latch |=> second_port_latch_reg === $past(second_port_latch_reg);
  endproperty
  a_second_keep: assert property (p_second_keep) else $error("reset changed second port latch");

  property p_first_rd_out;
    reg_rd && reg_addr == A_FIRST_LATCH && first_port_direction_reg == '1 |=> reg_rdata == $past(pb_out);
  endproperty
  a_first_rd_out: assert property (p_first_rd_out) else $error("output pin read not latch");

  property p_second_rd_in;
    reg_rd && reg_addr == A_SECOND_LATCH && second_port_direction_reg == '0 |=> reg_rdata == $past(pd_in, 3);
  endproperty
  a_second_rd_in: assert property (p_second_rd_in) else $error("input pin read not pin level");

  property p_latch_wr;
    wr_second_latch && second_port_direction_reg == '0 |=> second_port_latch_reg == $past(reg_wdata);
  endproperty
  a_latch_wr: assert property (p_latch_wr) else $error("latch write lost on input port");

  sequence s_wr_in;
    wr_second_latch && second_port_direction_reg == '0;
  endsequence
  sequence s_rd_in;
    reg_rd && reg_addr == A_SECOND_LATCH;
  endsequence
  property p_in_rd;
    s_wr_in ##1 s_rd_in |=> reg_rdata == $past(pd_sync);
  endproperty
  a_in_rd: assert property (p_in_rd) else $error("latch write altered input readback");

  property p_ser;
    serial_iface_enable |=> pd_oe[6] && !pd_oe[7] && pd_out[6] == $past(ser_tx);
  endproperty
  a_ser: assert property (p_ser) else $error("serial enable did not take pins 6 and 7");

  property p_tmr;
    els0 != ELS_GPIO |=> pd_oe[PIN_TMR0] == $past(tmr_oe[0]) && pd_out[PIN_TMR0] == $past(tmr_out[0]);
  endproperty
  a_tmr: assert property (p_tmr) else $error("timer select did not take pin 4");

  property p_slow;
    !serial_iface_enable && !(two_wire_enable && tw_route) && slow_edge[0] && second_port_direction_reg[6]
      |=> !pd_out[6] && pd_oe[6] == !$past(second_port_latch_reg[6]);
  endproperty
  a_slow: assert property (p_slow) else $error("slow edge pin not open-drain");

  property p_pullup;
    wr_drive |=> pd_pullup_en == {$past(reg_wdata[F_PU7]), $past(reg_wdata[F_PU6])};
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up bit not applied");

  property p_tw;
    !serial_iface_enable && two_wire_enable && tw_route |=> pd_oe[7] == $past(tw_low[1]) && !pd_out[7];
  endproperty
  a_tw: assert property (p_tw) else $error("two-wire lines not routed");

  property p_ser_prio;
    serial_iface_enable && two_wire_enable && tw_route |=> pd_oe[6] && !pd_oe[7];
  endproperty
  a_ser_prio: assert property (p_ser_prio) else $error("two-wire took pins from serial");

  property p_sync;
    $past(rst_n, 2) |-> pb_sync == $past(pb_in, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("pin sample not two clocks late");

endmodule : gdp_gpio

`default_nettype wire

/* gdp_pkg.sv */
// Purpose: constants shared by the dual-port pin logic
// Assumes: 8-bit register port, one clock, synchronous reset
// Notes: offsets are register indices on the plain register port

`default_nettype none

package gdp_pkg;

  // register indices
  localparam logic [7:0] A_FIRST_LATCH = 8'h01;
  localparam logic [7:0] A_SECOND_LATCH = 8'h03;
  localparam logic [7:0] A_FIRST_DIR = 8'h05;
  localparam logic [7:0] A_SECOND_DIR = 8'h07;
  localparam logic [7:0] A_DRIVE_CTL = 8'h0a;
  localparam logic [7:0] A_SHARE_CTL = 8'h0b;

  // drive control fields
  localparam int unsigned F_SLOW6 = 0;
  localparam int unsigned F_SLOW7 = 1;
  localparam int unsigned F_PU6 = 4;
  localparam int unsigned F_PU7 = 5;
  localparam logic [7:0] DRIVE_MASK = 8'h33;

  // pin sharing control fields
  localparam int unsigned F_SER_EN = 0;
  localparam int unsigned F_TW_EN = 1;
  localparam int unsigned F_TW_ROUTE = 2;
  localparam int unsigned F_ELS0 = 3;
  localparam int unsigned F_ELS1 = 5;
  localparam logic [7:0] SHARE_MASK = 8'h7f;

  // reset values
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] RD_IDLE = 8'h00;

  // timer select value that leaves the pin to the port
  localparam logic [1:0] ELS_GPIO = 2'b00;

  // shared pin positions on the second port
  localparam int unsigned PIN_TMR0 = 4;
  localparam int unsigned PIN_TMR1 = 5;
  localparam int unsigned PIN_HC6 = 6;

  // owner of a high-current pin
  typedef enum logic [1:0] {
    OWN_GPIO,
    OWN_SERIAL,
    OWN_TWO_WIRE
  } gdp_own_e;

endpackage : gdp_pkg

`default_nettype wire

/* gdp_pin_model.sv */
// Purpose: pins and outside world seen by the dual-port pin logic
// Assumes: the bench sets what the outside world drives
// Notes: a pin the block drives shows its own buffer value

`timescale 1ns/1ps
`default_nettype none

module gdp_pin_model (
  input wire logic [7:0] pb_out,
  input wire logic [7:0] pb_oe,
  input wire logic [7:0] pd_out,
  input wire logic [7:0] pd_oe,
  input wire logic [1:0] pd_pullup_en,
  input wire logic [7:0] ext_b,
  input wire logic [7:0] ext_d,
  output logic [7:0] pb_in,
  output logic [7:0] pd_in
);
  ////////////////////////////////////////////////////////////////////////////
  // first port: released pins follow the outside driver
  assign pb_in = (pb_oe & pb_out) | (~pb_oe & ext_b);
  // pull-ups only lift released pins, so open-drain lows still win
  assign pd_in = (pd_oe & pd_out) | (~pd_oe & (ext_d | {pd_pullup_en, 6'h00}));
endmodule : gdp_pin_model

`default_nettype wire

/* gdp_gpio_bench.sv */
// Purpose: self-checking bench for the dual-port pin logic
// Assumes: pins pass a 2-flop sync, second-port pin drive lags one clock
// Notes: settle waits cover sync plus drive register

`timescale 1ns/1ps
`default_nettype none

module gdp_gpio_bench;
  import gdp_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic ser_tx = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] ext_b = 8'h00;
  logic [7:0] ext_d = 8'h00;
  logic [1:0] tmr_out = 2'h0;
  logic [1:0] tmr_oe = 2'h0;
  logic [1:0] tw_low = 2'h0;
  wire logic [7:0] reg_rdata, pb_in, pb_out, pb_oe, pd_in, pd_out, pd_oe;
  wire logic [1:0] pd_pullup_en, pd_slow_edge, tmr_in, tw_in;
  wire logic ser_rx;
  int bad_count = 0;
  int samples_checked = 0;

  gdp_gpio #(.PORT_W(8)) u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe),
    .pd_in(pd_in), .pd_out(pd_out), .pd_oe(pd_oe), .pd_pullup_en(pd_pullup_en), .pd_slow_edge(pd_slow_edge),
    .ser_tx(ser_tx), .ser_rx(ser_rx), .tmr_out(tmr_out), .tmr_oe(tmr_oe), .tmr_in(tmr_in), .tw_low(tw_low),
    .tw_in(tw_in));
  gdp_pin_model u_pins (.pb_out(pb_out), .pb_oe(pb_oe), .pd_out(pd_out), .pd_oe(pd_oe),
    .pd_pullup_en(pd_pullup_en), .ext_b(ext_b), .ext_d(ext_d), .pb_in(pb_in), .pd_in(pd_in));

  ////////////////////////////////////////////////////////////////////////////
  // 50 MHz clock
  initial begin
    forever #10 clk = ~clk;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one-cycle write strobe, then a free edge before the next request
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(what, reg_rdata, exp);
  endtask : rd_chk

  // write then read the same index with no gap between the strobes
  task automatic wr_rd_chk(input string what, input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(what, reg_rdata, exp);
  endtask : wr_rd_chk

  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask : settle

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    wr(A_FIRST_LATCH, 8'ha5);
    wr(A_SECOND_LATCH, 8'h3c);
    wr(A_FIRST_DIR, 8'hff);
    wr(A_SECOND_DIR, 8'hff);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check("pb_oe", pb_oe, 8'h00);
    check("pd_oe", pd_oe, 8'h00);
    check("pb_out", pb_out, 8'ha5);
    rd_chk("dir b", A_FIRST_DIR, 8'h00);
    rd_chk("dir d", A_SECOND_DIR, 8'h00);
    wr(A_FIRST_DIR, 8'hff);
    wr(A_SECOND_DIR, 8'hff);
    rd_chk("latch b", A_FIRST_LATCH, 8'ha5);
    rd_chk("latch d", A_SECOND_LATCH, 8'h3c);
  endtask : t_reset

  task automatic t_port_b();
    @(posedge clk);
    ext_b <= 8'hc3;
    wr(A_FIRST_DIR, 8'hf0);
    wr(A_FIRST_LATCH, 8'h5a);
    settle();
    check("pb_oe", pb_oe, 8'hf0);
    rd_chk("read b", A_FIRST_LATCH, 8'h53);
    wr(A_FIRST_LATCH, 8'hff);
    #1;
    check("pb_out", pb_out, 8'hff);
    rd_chk("read b input", A_FIRST_LATCH, 8'hf3);
  endtask : t_port_b

  task automatic t_port_d();
    @(posedge clk);
    ext_d <= 8'h5a;
    wr(A_SECOND_DIR, 8'h0f);
    wr(A_SECOND_LATCH, 8'h96);
    settle();
    check("pd_oe", pd_oe, 8'h0f);
    check("pd_out", pd_out & 8'h0f, 8'h06);
    rd_chk("read d", A_SECOND_LATCH, 8'h56);
  endtask : t_port_d

  // serial wins pins 6/7 even with two-wire routed there
  task automatic t_serial();
    @(posedge clk);
    ext_d <= 8'h80;
    ser_tx <= 1'b1;
    wr(A_SECOND_LATCH, 8'h00);
    wr(A_SECOND_DIR, 8'hff);
    wr(A_SHARE_CTL, 8'h07);
    settle();
    check("ser oe", {6'h00, pd_oe[7:6]}, 8'h01);
    check("tx pin", {7'h00, pd_out[6]}, 8'h01);
    check("ser_rx", {7'h00, ser_rx}, 8'h01);
    @(posedge clk);
    ser_tx <= 1'b0;
    ext_d <= 8'h00;
    settle();
    check("tx pin", {7'h00, pd_out[6]}, 8'h00);
    check("ser_rx", {7'h00, ser_rx}, 8'h00);
  endtask : t_serial

  task automatic t_two_wire();
    @(posedge clk);
    ext_d <= 8'h40;
    tw_low <= 2'b10;
    wr(A_SHARE_CTL, 8'h06);
    settle();
    check("tw oe", {6'h00, pd_oe[7:6]}, 8'h02);
    check("tw out", {7'h00, pd_out[7]}, 8'h00);
    check("tw_in", {6'h00, tw_in}, 8'h01);
    wr(A_SHARE_CTL, 8'h02);
    settle();
    check("unrouted oe", {6'h00, pd_oe[7:6]}, 8'h03);
  endtask : t_two_wire

  // every non-port edge/level code hands pins 4/5 to the timer
  task automatic t_timer();
    logic [7:0] sel;
    @(posedge clk);
    tmr_oe <= 2'b10;
    tmr_out <= 2'b11;
    ext_d <= 8'h10;
    wr(A_SECOND_DIR, 8'h00);
    for (sel = 8'h01; sel < 8'h04; sel++) begin
      wr(A_SHARE_CTL, (sel << F_ELS0) | (sel << F_ELS1));
      settle();
      check("tmr oe", {6'h00, pd_oe[5:4]}, 8'h02);
      check("tmr out", {7'h00, pd_out[5]}, 8'h01);
      check("tmr_in", {6'h00, tmr_in}, 8'h03);
    end
    wr(A_SHARE_CTL, 8'h00);
    settle();
    check("gpio oe", {6'h00, pd_oe[5:4]}, 8'h00);
  endtask : t_timer

  task automatic t_drive();
    wr(A_SECOND_LATCH, 8'h80);
    wr(A_SECOND_DIR, 8'hff);
    wr(A_DRIVE_CTL, 8'hff);
    rd_chk("drive ctl", A_DRIVE_CTL, 8'h33);
    settle();
    check("slow", {6'h00, pd_slow_edge}, 8'h03);
    check("pullup", {6'h00, pd_pullup_en}, 8'h03);
    check("od oe", {6'h00, pd_oe[7:6]}, 8'h01);
    check("od out", {6'h00, pd_out[7:6]}, 8'h00);
    rd_chk("dir d kept", A_SECOND_DIR, 8'hff);
    wr(A_SECOND_DIR, 8'h00);
    wr(A_DRIVE_CTL, 8'h10);
    settle();
    check("pullup in", {6'h00, pd_pullup_en}, 8'h01);
    check("slow off", {6'h00, pd_slow_edge}, 8'h00);
    wr_rd_chk("pulled pin", A_SECOND_LATCH, 8'hff, 8'h50);
  endtask : t_drive

  task automatic t_map();
    wr(8'h02, 8'hff);
    rd_chk("unmapped", 8'h02, 8'h00);
    rd_chk("dir b kept", A_FIRST_DIR, 8'hf0);
    wr(A_SHARE_CTL, 8'hff);
    rd_chk("share ctl", A_SHARE_CTL, 8'h7f);
  endtask : t_map

  task automatic wrap_up();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////
  // watchdog well past the some 160 cycles the tests need
  initial begin
    #200000;
    bad_count++;
    wrap_up();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_port_b();
    t_port_d();
    t_serial();
    t_two_wire();
    t_timer();
    t_drive();
    t_map();
    wrap_up();
  end
endmodule : gdp_gpio_bench

`default_nettype wire
